// ===== shared/usbdec_pkg.sv
// Function
// - setup token sets the hold flag; while held, packets are neither sent nor taken.
// - software clearing the hold flag lets token processing continue.
// - resume drive output follows control bit 2 for remote wakeup.
// - writing 1 to bank-clear forces ping-pong bits of endpoints 5 and 6 even.
// - module enable bit gates token decoding, frame capture and engine_active, transceiver and regulator untouched.
// - setting module enable clears ping-pong bits and reinitialises engine state.
// - only tokens whose address equals the 7-bit device address are decoded; start-of-frame loads the frame number at any address.
// - device address returns to zero on reset input or on bus reset.
// - 11-bit frame number split: low byte bits 7-0, high register bits 2-0.
// - frame number registers load on every start-of-frame token while the module enable bit is set.
// - one control register for each endpoint 0 to 6.
// - receive/transmit enables decode direction; setup needs both with bit 4 clear.
// - stall bit answers every access with a stall, overriding other settings.
// - stall acts only when the endpoint has transmit or receive enabled.
// - handshake bit at 0 suppresses handshake packets for that endpoint.
// - completed transaction records endpoint, direction and bank used.
package usbdec_pkg;

  // ***********************************
  // register map
  // ***********************************
  localparam logic [3:0] USBDEC_OFS_CTL    = 4'h0;
  localparam logic [3:0] USBDEC_OFS_ADDR   = 4'h1;
  localparam logic [3:0] USBDEC_OFS_FRML   = 4'h2;
  localparam logic [3:0] USBDEC_OFS_FRMH   = 4'h3;
  localparam logic [3:0] USBDEC_OFS_EP0    = 4'h4;
  localparam logic [3:0] USBDEC_OFS_STAT   = 4'hb;
  localparam int         USBDEC_NUM_EP     = 7;

  // ***********************************
  // field positions
  // ***********************************
  localparam int USBDEC_CTL_HOLD    = 5;
  localparam int USBDEC_CTL_RESUME  = 2;
  localparam int USBDEC_CTL_BANKCLR = 1;
  localparam int USBDEC_CTL_ENABLE  = 0;
  localparam int USBDEC_EP_CTLDIS   = 4;
  localparam int USBDEC_EP_RXEN     = 3;
  localparam int USBDEC_EP_TXEN     = 2;
  localparam int USBDEC_EP_HALT     = 1;
  localparam int USBDEC_EP_HSHK     = 0;

  // ***********************************
  // reset values
  // ***********************************
  localparam logic [7:0]  USBDEC_RST_BYTE  = 8'h00;
  localparam logic [6:0]  USBDEC_RST_ADDR  = 7'h00;
  localparam logic [4:0]  USBDEC_RST_EP    = 5'h00;
  localparam logic [10:0] USBDEC_RST_FRAME = 11'h000;

  // token kinds delivered by the packet decoder
  typedef enum logic [1:0] {
    USBDEC_TOK_OUT   = 2'h0,
    USBDEC_TOK_IN    = 2'h1,
    USBDEC_TOK_SOF   = 2'h2,
    USBDEC_TOK_SETUP = 2'h3
  } usbdec_tok_t;

  // answer to a token
  typedef enum logic [1:0] {
    USBDEC_RESP_IGNORE = 2'h0,
    USBDEC_RESP_HSHK   = 2'h1,
    USBDEC_RESP_NOHSHK = 2'h2,
    USBDEC_RESP_STALL  = 2'h3
  } usbdec_resp_t;

endpackage : usbdec_pkg

// ===== hw/usbdec_endpoint_control.sv
`timescale 1ns/10ps
module usbdec_endpoint_control
  import usbdec_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // token side from the packet decoder
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_kind,
  input  wire logic [6:0]  tok_addr,
  input  wire logic [3:0]  tok_endp,
  input  wire logic [10:0] tok_frame,
  input  wire logic        bus_reset_seen,
  input  wire logic        xfer_done,
  // answers to the engine
  output logic             resp_valid,
  output logic      [1:0]  resp_kind,
  output logic             engine_active,
  output logic             remote_wakeup_drive,
  output logic      [1:0]  pingpong_odd
);

  // ***********************************
  // decode helpers
  // ***********************************

  // a reserved enable pattern still takes IN and OUT; only SETUP is refused there
  // endpoint takes this token kind by its enable bits
  function automatic logic usbdec_dir_ok(input logic [4:0] ctl, input logic [1:0] kind);
    logic ok;
    ok = 1'b0;
    unique case (kind)
      USBDEC_TOK_OUT:   ok = ctl[USBDEC_EP_RXEN];
      USBDEC_TOK_IN:    ok = ctl[USBDEC_EP_TXEN];
      USBDEC_TOK_SETUP: ok = ctl[USBDEC_EP_RXEN] & ctl[USBDEC_EP_TXEN]
                             & ~ctl[USBDEC_EP_CTLDIS];
      USBDEC_TOK_SOF:   ok = 1'b0;
    endcase
    return ok;
  endfunction : usbdec_dir_ok

  // halt only counts on a live endpoint
  function automatic logic usbdec_halted(input logic [4:0] ctl);
    return ctl[USBDEC_EP_HALT] & (ctl[USBDEC_EP_RXEN] | ctl[USBDEC_EP_TXEN]);
  endfunction : usbdec_halted

  // register index lands on one of the endpoint control registers
  function automatic logic usbdec_ep_hit(input logic [3:0] addr);
    return (addr >= USBDEC_OFS_EP0) && (addr < USBDEC_OFS_EP0 + 4'(USBDEC_NUM_EP));
  endfunction : usbdec_ep_hit

  // endpoint behind a register index; only meaningful together with the hit test
  function automatic logic [2:0] usbdec_ep_sel(input logic [3:0] addr);
    return 3'(addr - USBDEC_OFS_EP0);
  endfunction : usbdec_ep_sel

  // ***********************************
  // state
  // ***********************************
  logic             enable_reg;
  logic             hold_reg;
  logic             resume_reg;
  logic [6:0]       dev_addr_reg;
  logic [10:0]      frame_reg;
  // per endpoint: setup-disable, receive, transmit, halt and handshake bits
  logic [4:0]       ep_ctl_reg [USBDEC_NUM_EP];
  logic [1:0]       odd_reg;
  // transaction record shown at the status index
  logic [3:0]       stat_endp_reg;
  logic             stat_in_reg;
  logic             stat_odd_reg;
  logic             pend_reg;
  logic [3:0]       pend_endp_reg;
  logic             pend_in_reg;
  logic [7:0]       rdata_reg;
  logic             resp_valid_reg;
  logic [1:0]       resp_kind_reg;
  logic             active_reg;

  // ***********************************
  // combinational decode
  // ***********************************
  logic             wr_ctl;
  logic             wr_addr;
  logic             enable_rise;
  logic             bank_clear;
  logic             ep_in_range;
  logic [4:0]       tok_ep_ctl;
  logic             tok_for_us;
  logic             tok_data;
  logic             tok_taken;
  logic [1:0]       resp_next;
  logic             setup_hit;
  logic [7:0]       rdata_next;

  // ***********************************
  // register strobes
  // ***********************************
  // writes to control and address, and the enable edge that restarts the engine
  assign wr_ctl      = reg_wr && (reg_addr == USBDEC_OFS_CTL);
  assign wr_addr     = reg_wr && (reg_addr == USBDEC_OFS_ADDR);
  assign enable_rise = wr_ctl && reg_wdata[USBDEC_CTL_ENABLE] && !enable_reg;
  assign bank_clear  = (wr_ctl && reg_wdata[USBDEC_CTL_BANKCLR]) || enable_rise;
  // endpoint numbers above 6 have no register: refuse them rather than alias
  assign ep_in_range = (tok_endp < 4'(USBDEC_NUM_EP));
  assign tok_ep_ctl  = ep_in_range ? ep_ctl_reg[tok_endp[2:0]] : USBDEC_RST_EP;

  // token aimed at this device while it runs
  assign tok_for_us  = tok_valid && enable_reg && (tok_addr == dev_addr_reg);
  // data tokens are refused while the hold flag stands
  assign tok_data    = tok_for_us && (tok_kind != USBDEC_TOK_SOF)
                       && !hold_reg && ep_in_range;

  // ***********************************
  // token answer
  // ***********************************

  // on a live endpoint, halt wins over every other control setting
  always_comb begin
    resp_next = USBDEC_RESP_IGNORE;
    if (tok_data) begin
      if (usbdec_halted(tok_ep_ctl)) begin
        resp_next = USBDEC_RESP_STALL;
      end else if (usbdec_dir_ok(tok_ep_ctl, tok_kind)) begin
        resp_next = tok_ep_ctl[USBDEC_EP_HSHK] ? USBDEC_RESP_HSHK
                                               : USBDEC_RESP_NOHSHK;
      end
    end
  end

  // only an accepted token starts a transaction; stall and ignore leave nothing pending
  assign tok_taken = (resp_next == USBDEC_RESP_HSHK) || (resp_next == USBDEC_RESP_NOHSHK);
  assign setup_hit = tok_taken && (tok_kind == USBDEC_TOK_SETUP);

  // answer stands one cycle after the token
  // a refused token still gets an ignore answer, so the engine never waits for one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp_valid_reg <= 1'b0;
      resp_kind_reg  <= USBDEC_RESP_IGNORE;
    end else begin
      resp_valid_reg <= tok_valid && (tok_kind != USBDEC_TOK_SOF);
      resp_kind_reg  <= resp_next;
    end
  end

  // ***********************************
  // control register
  // ***********************************

  // enable and resume are plain software bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= 1'b0;
      resume_reg <= 1'b0;
    end else if (wr_ctl) begin
      enable_reg <= reg_wdata[USBDEC_CTL_ENABLE];
      resume_reg <= reg_wdata[USBDEC_CTL_RESUME];
    end
  end

  // hold flag: a setup in the clearing cycle still sets it
  // writing 1 to the bit has no effect; only a setup raises it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (setup_hit) begin
      hold_reg <= 1'b1;
    end else if (enable_rise) begin
      hold_reg <= 1'b0;
    end else if (wr_ctl && !reg_wdata[USBDEC_CTL_HOLD]) begin
      hold_reg <= 1'b0;
    end
  end

  // engine may move packets only when enabled and not held
  // follows the control bits one cycle late; the setup term drops it with the flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= enable_reg && !hold_reg && !setup_hit;
    end
  end

  // ***********************************
  // device address
  // ***********************************

  // bus reset beats a software write in the same cycle
  // that write is lost, which is harmless: firmware sets the address after the reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dev_addr_reg <= USBDEC_RST_ADDR;
    end else if (bus_reset_seen) begin
      dev_addr_reg <= USBDEC_RST_ADDR;
    end else if (wr_addr) begin
      dev_addr_reg <= reg_wdata[6:0];
    end
  end

  // ***********************************
  // frame number
  // ***********************************

  // start of frame is broadcast, so address and hold do not gate it
  // low and high halves are not latched together; a read pair can straddle a frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_reg <= USBDEC_RST_FRAME;
    end else if (tok_valid && enable_reg && (tok_kind == USBDEC_TOK_SOF)) begin
      frame_reg <= tok_frame;
    end
  end

  // ***********************************
  // endpoint control registers
  // ***********************************
  generate
    for (genvar ep = 0; ep < USBDEC_NUM_EP; ep++) begin : g_ep
      // hardware never touches halt; only software writes change it
      // bits 7 to 5 are not stored, so they read back as 0
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          ep_ctl_reg[ep] <= USBDEC_RST_EP;
        end else if (reg_wr && usbdec_ep_hit(reg_addr) &&
                     (usbdec_ep_sel(reg_addr) == 3'(ep))) begin
          ep_ctl_reg[ep] <= reg_wdata[4:0];
        end
      end
    end
  endgenerate

  // ***********************************
  // transaction record and ping-pong banks
  // ***********************************

  // remember the taken token until the engine reports completion
  // a token taken in the same cycle as a completion takes the slot over
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_reg      <= 1'b0;
      pend_endp_reg <= 4'h0;
      pend_in_reg   <= 1'b0;
    end else if (enable_rise) begin
      pend_reg      <= 1'b0;
    end else if (tok_taken) begin
      pend_reg      <= 1'b1;
      pend_endp_reg <= tok_endp;
      pend_in_reg   <= (tok_kind == USBDEC_TOK_IN);
    end else if (xfer_done) begin
      pend_reg      <= 1'b0;
    end
  end

  // record endpoint, direction and bank of the finished transfer
  // one record only: a second completion before software looks overwrites the first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_endp_reg <= 4'h0;
      stat_in_reg   <= 1'b0;
      stat_odd_reg  <= 1'b0;
    end else if (enable_rise) begin
      stat_endp_reg <= 4'h0;
      stat_in_reg   <= 1'b0;
      stat_odd_reg  <= 1'b0;
    end else if (pend_reg && xfer_done) begin
      stat_endp_reg <= pend_endp_reg;
      stat_in_reg   <= pend_in_reg;
      stat_odd_reg  <= (pend_endp_reg == 4'h5) ? odd_reg[0] :
                       (pend_endp_reg == 4'h6) ? odd_reg[1] : 1'b0;
    end
  end

  // only endpoints 5 and 6 alternate; a clear overrides a toggle
  // the other endpoints run single-buffered and keep no bank bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      odd_reg <= 2'h0;
    end else if (bank_clear) begin
      odd_reg <= 2'h0;
    end else if (pend_reg && xfer_done) begin
      if (pend_endp_reg == 4'h5) begin
        odd_reg[0] <= ~odd_reg[0];
      end
      if (pend_endp_reg == 4'h6) begin
        odd_reg[1] <= ~odd_reg[1];
      end
    end
  end

  // ***********************************
  // read port
  // ***********************************

  // bank-clear is a command bit, so it always reads back 0
  // unmapped indices fall through to the zero default
  always_comb begin
    rdata_next = USBDEC_RST_BYTE;
    if (reg_addr == USBDEC_OFS_CTL) begin
      rdata_next[USBDEC_CTL_HOLD]   = hold_reg;
      rdata_next[USBDEC_CTL_RESUME] = resume_reg;
      rdata_next[USBDEC_CTL_ENABLE] = enable_reg;
    end else if (reg_addr == USBDEC_OFS_ADDR) begin
      rdata_next = {1'b0, dev_addr_reg};
    end else if (reg_addr == USBDEC_OFS_FRML) begin
      rdata_next = frame_reg[7:0];
    end else if (reg_addr == USBDEC_OFS_FRMH) begin
      rdata_next = {5'h00, frame_reg[10:8]};
    end else if (reg_addr == USBDEC_OFS_STAT) begin
      rdata_next = {stat_endp_reg, stat_in_reg, stat_odd_reg, 2'h0};
    end else if (usbdec_ep_hit(reg_addr)) begin
      rdata_next = {3'h0, ep_ctl_reg[usbdec_ep_sel(reg_addr)]};
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= USBDEC_RST_BYTE;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : USBDEC_RST_BYTE;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  // every output is a register, so the engine sees clean levels
  assign reg_rdata           = rdata_reg;
  assign resp_valid          = resp_valid_reg;
  assign resp_kind           = resp_kind_reg;
  assign engine_active       = active_reg;
  assign remote_wakeup_drive = resume_reg;
  assign pingpong_odd        = odd_reg;

endmodule : usbdec_endpoint_control

// ===== dv/usbdec_host_model.sv
`timescale 1ns/10ps
module usbdec_host_model
  import usbdec_pkg::*;
(
  // clock
  input  logic        core_clk,
  // token side toward the block
  output logic        tok_valid,
  output logic [1:0]  tok_kind,
  output logic [6:0]  tok_addr,
  output logic [3:0]  tok_endp,
  output logic [10:0] tok_frame,
  output logic        bus_reset_seen,
  output logic        xfer_done
);
  // quiet bus at time zero
  initial begin
    {tok_valid, tok_kind, tok_addr, tok_endp, tok_frame} = '0;
    {bus_reset_seen, xfer_done} = 2'h0;
  end

  // fields invert once the token is gone, so a stale value can never match
  task automatic token(input logic [1:0] k, input logic [6:0] a, input logic [3:0] e,
                       input logic [10:0] f);
    @(posedge core_clk);
    {tok_valid, tok_kind, tok_addr, tok_endp, tok_frame} <= {1'b1, k, a, e, f};
    @(posedge core_clk);
    {tok_valid, tok_kind, tok_addr, tok_endp, tok_frame} <= {1'b0, ~k, ~a, ~e, ~f};
  endtask : token

  // one-cycle event: bus reset when b is 1, transaction done otherwise
  task automatic event_pulse(input logic b);
    @(posedge core_clk);
    {bus_reset_seen, xfer_done} <= {b, ~b};
    @(posedge core_clk);
    {bus_reset_seen, xfer_done} <= 2'h0;
  endtask : event_pulse
endmodule : usbdec_host_model

// ===== dv/usbdec_endpoint_control_checker.sv
`timescale 1ns/10ps
module usbdec_endpoint_control_checker
  import usbdec_pkg::*;
(
  // clock and reset
  input logic        core_clk,
  input logic        rst,
  // register port
  input logic [3:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  // token side
  input logic        tok_valid,
  input logic [1:0]  tok_kind,
  input logic [6:0]  tok_addr,
  input logic [3:0]  tok_endp,
  input logic [10:0] tok_frame,
  input logic        bus_reset_seen,
  input logic        xfer_done,
  // answers
  input logic        resp_valid,
  input logic [1:0]  resp_kind,
  input logic        engine_active,
  input logic        remote_wakeup_drive,
  input logic [1:0]  pingpong_odd
);
  logic [6:0] addr_reg;
  logic       tok_ans;

  // device address mirror; bus reset beats a write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) addr_reg <= 7'h00;
    else if (bus_reset_seen) addr_reg <= 7'h00;
    else if (reg_wr && reg_addr == USBDEC_OFS_ADDR) addr_reg <= reg_wdata[6:0];
  end
  assign tok_ans = tok_valid && tok_kind != USBDEC_TOK_SOF;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_addr_filter: assert property (tok_ans && tok_addr != addr_reg |=> resp_kind == 2'h0)
    else $error("token for another address answered");
  a_addr_read: assert property (reg_rd && reg_addr == USBDEC_OFS_ADDR && !bus_reset_seen
    |=> reg_rdata == {1'b0, addr_reg}) else $error("device address read wrong");
  a_sof_silent: assert property (tok_valid && tok_kind == USBDEC_TOK_SOF |=> !resp_valid)
    else $error("start of frame answered");
  a_token_answer: assert property (tok_ans |=> resp_valid)
    else $error("token not answered");
  a_setup_hold: assert property (resp_valid && resp_kind inside {2'h1, 2'h2}
    && $past(tok_kind) == USBDEC_TOK_SETUP |-> !engine_active) else $error("setup left engine on");
  a_held_ignore: assert property (!engine_active && !reg_wr && !$past(reg_wr) && tok_ans
    |=> resp_kind == 2'h0) else $error("held engine answered");
  a_resume_bit: assert property (reg_wr && reg_addr == USBDEC_OFS_CTL
    |=> remote_wakeup_drive == $past(reg_wdata[2])) else $error("resume drive wrong");
  a_bank_clear: assert property (reg_wr && reg_addr == USBDEC_OFS_CTL && reg_wdata[1]
    |=> pingpong_odd == 2'h0) else $error("banks not cleared");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_ctl_unused: assert property (reg_rd && reg_addr == USBDEC_OFS_CTL
    |=> (reg_rdata & 8'hda) == 8'h00) else $error("control unused bits set");
  a_frmh_width: assert property (reg_rd && reg_addr == USBDEC_OFS_FRMH
    |=> reg_rdata[7:3] == 5'h00) else $error("frame high too wide");

  c_setup: cover property (tok_valid && tok_kind == USBDEC_TOK_SETUP ##1 resp_kind == 2'h1);
  c_stall: cover property (resp_valid && resp_kind == 2'h3);
  c_sof: cover property (tok_valid && tok_kind == USBDEC_TOK_SOF);
endmodule : usbdec_endpoint_control_checker

bind usbdec_endpoint_control usbdec_endpoint_control_checker chk_u (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
  .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp), .tok_frame(tok_frame),
  .bus_reset_seen(bus_reset_seen), .xfer_done(xfer_done), .resp_valid(resp_valid),
  .resp_kind(resp_kind), .engine_active(engine_active),
  .remote_wakeup_drive(remote_wakeup_drive), .pingpong_odd(pingpong_odd));

// ===== dv/usbdec_endpoint_control_test.sv
`timescale 1ns/10ps
module usbdec_endpoint_control_test import usbdec_pkg::*;;
  logic core_clk, rst, reg_wr, reg_rd, tok_valid, bus_reset_seen, xfer_done;
  logic resp_valid, engine_active, remote_wakeup_drive;
  logic [3:0] reg_addr, tok_endp;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] tok_kind, resp_kind, pingpong_odd;
  logic [6:0] tok_addr;
  logic [10:0] tok_frame;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  // enables and stall per entry: {ep value, token kind, answer}
  localparam logic [11:0] DIRS [12] = '{12'h004, 12'h055, 12'h046, 12'h040, 12'h091, 12'h09c,
                                        12'h0dd, 12'h1dc, 12'h1d1, 12'he63, 12'h024, 12'h0f7};

  usbdec_endpoint_control dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp),
    .tok_frame(tok_frame), .bus_reset_seen(bus_reset_seen), .xfer_done(xfer_done),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .engine_active(engine_active),
    .remote_wakeup_drive(remote_wakeup_drive), .pingpong_odd(pingpong_odd));
  usbdec_host_model host_u (.core_clk(core_clk), .tok_valid(tok_valid), .tok_kind(tok_kind),
    .tok_addr(tok_addr), .tok_endp(tok_endp), .tok_frame(tok_frame),
    .bus_reset_seen(bus_reset_seen), .xfer_done(xfer_done));

  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ***********************************
  // bus and compare helpers
  // ***********************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  task automatic tok(input logic [1:0] k, input logic [6:0] a, input logic [3:0] e,
                     input logic [1:0] x);
    host_u.token(k, a, e, 11'h000);
    #1 chk({5'h00, resp_valid, resp_kind}, {5'h00, 1'b1, x});
  endtask : tok

  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_reset();
    for (int a = 0; a < 13; a++) rd(a[3:0], 8'h00);
    chk({6'h00, engine_active, remote_wakeup_drive}, 8'h00);
  endtask : t_reset

  task automatic t_setup_hold();
    wr(USBDEC_OFS_CTL, 8'h01);
    wr(USBDEC_OFS_ADDR, 8'h85);
    wr(USBDEC_OFS_EP0, 8'h0d);
    rd(USBDEC_OFS_ADDR, 8'h05);
    tok(USBDEC_TOK_SETUP, 7'h05, 4'h0, 2'h1);
    rd(USBDEC_OFS_CTL, 8'h21);
    chk({7'h00, engine_active}, 8'h00);
    tok(USBDEC_TOK_OUT, 7'h05, 4'h0, 2'h0);
    wr(USBDEC_OFS_CTL, 8'h01);
    tok(USBDEC_TOK_OUT, 7'h05, 4'h0, 2'h1);
    chk({7'h00, engine_active}, 8'h01);
    tok(USBDEC_TOK_IN, 7'h06, 4'h0, 2'h0);
    tok(USBDEC_TOK_IN, 7'h05, 4'h7, 2'h0);
    host_u.event_pulse(1'b1);
    rd(USBDEC_OFS_ADDR, 8'h00);
    tok(USBDEC_TOK_IN, 7'h00, 4'h0, 2'h1);
    wr(USBDEC_OFS_ADDR, 8'h05);
  endtask : t_setup_hold

  task automatic t_dirs();
    for (int i = 0; i < 12; i++) begin
      wr(USBDEC_OFS_CTL, 8'h01);
      wr(USBDEC_OFS_EP0 + 4'h1, DIRS[i][11:4]);
      tok(DIRS[i][3:2], 7'h05, 4'h1, DIRS[i][1:0]);
      rd(USBDEC_OFS_EP0 + 4'h1, DIRS[i][11:4] & 8'h1f);
    end
  endtask : t_dirs

  task automatic t_frame();
    host_u.token(USBDEC_TOK_SOF, 7'h33, 4'h9, 11'h5a3);
    #1 chk({7'h00, resp_valid}, 8'h00);
    rd(USBDEC_OFS_FRML, 8'ha3);
    rd(USBDEC_OFS_FRMH, 8'h05);
    host_u.token(USBDEC_TOK_SOF, 7'h05, 4'h0, 11'h7ff);
    rd(USBDEC_OFS_FRMH, 8'h07);
  endtask : t_frame

  // software keeps resume up for a while, then drops it
  task automatic t_resume();
    wr(USBDEC_OFS_CTL, 8'h05);
    chk({7'h00, remote_wakeup_drive}, 8'h01);
    repeat (10) @(posedge core_clk);
    wr(USBDEC_OFS_CTL, 8'h01);
    chk({7'h00, remote_wakeup_drive}, 8'h00);
  endtask : t_resume

  task automatic t_bank();
    wr(4'h9, 8'h0d);
    tok(USBDEC_TOK_IN, 7'h05, 4'h5, 2'h1);
    host_u.event_pulse(1'b0);
    rd(USBDEC_OFS_STAT, 8'h58);
    chk({6'h00, pingpong_odd}, 8'h01);
    // endpoint 6, then endpoint 5 again: its record must show the odd bank
    wr(4'ha, 8'h0d);
    tok(USBDEC_TOK_IN, 7'h05, 4'h6, 2'h1);
    host_u.event_pulse(1'b0);
    tok(USBDEC_TOK_IN, 7'h05, 4'h5, 2'h1);
    host_u.event_pulse(1'b0);
    rd(USBDEC_OFS_STAT, 8'h5c);
    chk({6'h00, pingpong_odd}, 8'h02);
    wr(USBDEC_OFS_CTL, 8'h03);
    chk({6'h00, pingpong_odd}, 8'h00);
    rd(USBDEC_OFS_CTL, 8'h01);
    tok(USBDEC_TOK_IN, 7'h05, 4'h5, 2'h1);
    host_u.event_pulse(1'b0);
    wr(USBDEC_OFS_CTL, 8'h00);
    tok(USBDEC_TOK_IN, 7'h05, 4'h5, 2'h0);
    wr(USBDEC_OFS_CTL, 8'h01);
    chk({6'h00, pingpong_odd}, 8'h00);
    rd(USBDEC_OFS_STAT, 8'h00);
  endtask : t_bank

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // reset for 20 cycles, then the scenarios in turn
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 14'h0000};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_setup_hold();
    t_dirs();
    t_frame();
    t_resume();
    t_bank();
    close_out();
  end
endmodule : usbdec_endpoint_control_test
